// *** pkg/dac_sli_pkg.sv ***
// Purpose: shared constants and types of the serial load interface
// Assumes: one 16-bit word = 4 command bits over 12 data bits
// Notes: register offsets are byte addresses on the AXI4-Lite slave
package dac_sli_pkg;
    // word layout
    localparam int WORD_W = 16;
    localparam int CMD_W = 4;
    localparam int DATA_W = 12;
    localparam int CNT_W = 5;
    localparam logic [4:0] WORD_EDGES = 5'h10; // active edges per word
    localparam logic [4:0] LAST_EDGE = 5'h0f; // count before the final edge
    // command field codes
    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_LOAD = 4'h1,
        CMD_READBACK = 4'h2,
        CMD_CHAIN_OFF = 4'h9,
        CMD_RISE_EDGE = 4'ha,
        CMD_CLEAR_ZERO = 4'hb,
        CMD_CLEAR_MID = 4'hc
    } cmd_e;
    // converter codes and values after reset
    localparam logic [11:0] CODE_ZERO = 12'h000;
    localparam logic [11:0] CODE_MID = 12'h800;
    localparam logic [11:0] DAC_RST = 12'h000;
    localparam logic RISE_RST = 1'b0; // falling-edge capture
    localparam logic CHAIN_RST = 1'b1; // chained mode
    // register map
    localparam logic [11:0] ADDR_STATUS = 12'h000;
    localparam logic [11:0] ADDR_WORD = 12'h004;
    localparam logic [11:0] ADDR_CTRL = 12'h008;
    localparam int STAT_RISE_BIT = 16;
    localparam int STAT_CHAIN_BIT = 17;
    localparam int STAT_RBPEND_BIT = 18;
    localparam int STAT_FRAME_BIT = 19;
    localparam int CTRL_DEFAULTS_BIT = 0;
    typedef enum logic [1:0] {
        REG_NONE = 2'h0,
        REG_STATUS = 2'h1,
        REG_WORD = 2'h2,
        REG_CTRL = 2'h3
    } reg_e;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** pkg/shift_link_if.sv ***
// Purpose: bundle between the serial-clock shifter and the core logic
// Assumes: mode fields change only while no word shifts; rb_pend clears a few aclk after the first edge of a frame
// Notes: toggles carry events from the serial clock into aclk
`timescale 1ns/1ps
interface shift_link_if;
    logic [15:0] word; // shift register contents
    logic done_tgl; // flips on the final edge of a stand-alone word
    logic ack_tgl; // flips when a readback word was taken
    logic rise_mode; // capture on rising serial clock edges
    logic chain_mode; // execute on frame release
    logic rb_pend; // readback word waits for the next frame
    logic [15:0] rb_word; // word presented during readback
    modport link(
        output word, done_tgl, ack_tgl,
        input rise_mode, chain_mode, rb_pend, rb_word
    );
    modport core(
        input word, done_tgl, ack_tgl,
        output rise_mode, chain_mode, rb_pend, rb_word
    );
endinterface

// *** src/serial_shifter.sv ***
// Purpose: serial-clock side: shift register, edge counter, data out
// Assumes: serial clock only toggles while frame select is low
// Notes: edge choice is a clock mux, switched only between words
`timescale 1ns/1ps
module serial_shifter (
    input wire logic sclk,
    input wire logic link_rst,
    input wire logic frame_sel_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    shift_link_if.link lnk
);
    logic act_clk; // capturing edge is its rising edge
    logic idle_clk; // the opposite edge
    logic frame_clr; // frame released or reset
    logic [15:0] shift_q;
    logic [4:0] cnt_q;
    logic out_bit_q; // bit leaving the register at the last shift
    logic sdo_q;
    logic done_q;
    logic ack_q;
    logic full;
    logic shift_en;
    logic first;

    // select capturing edge from the mode bit
    assign act_clk = lnk.rise_mode ? sclk : ~sclk; // RULE1 RULE2
    assign idle_clk = ~act_clk;
    assign frame_clr = link_rst | frame_sel_n;
    assign full = (cnt_q == dac_sli_pkg::WORD_EDGES);
    // stand-alone words stop at the final edge, chains keep passing bits
    assign shift_en = !frame_sel_n && (lnk.chain_mode || !full); // RULE4
    assign first = (cnt_q == 5'h00);
    assign lnk.word = shift_q;
    assign lnk.done_tgl = done_q;
    assign lnk.ack_tgl = ack_q;
    assign serial_data_out = sdo_q;

    ////////////////////////////////////////////////////////////////////
    // edge counter, cleared while the frame is released
    always_ff @(posedge act_clk or posedge frame_clr) begin
        if (frame_clr) begin
            cnt_q <= 5'h00; // RULE10
        end else if (!full) begin
            cnt_q <= cnt_q + 5'h01; // RULE5
        end
    end

    // shift register, event toggles and outgoing bit
    always_ff @(posedge act_clk or posedge link_rst) begin
        if (link_rst) begin
            shift_q <= 16'h0000;
            out_bit_q <= 1'b0;
            done_q <= 1'b0;
            ack_q <= 1'b0;
        end else if (shift_en) begin
            if (first && lnk.rb_pend) begin
                // readback replaces the old word at the frame start
                shift_q <= {lnk.rb_word[14:0], serial_data_in}; // RULE7
                out_bit_q <= lnk.rb_word[15]; // RULE7
                ack_q <= ~ack_q;
            end else if (first && !lnk.chain_mode) begin
                // an aborted word never survives into the next frame
                shift_q <= {15'h0000, serial_data_in}; // RULE10
                out_bit_q <= shift_q[15];
            end else begin
                shift_q <= {shift_q[14:0], serial_data_in}; // RULE3
                out_bit_q <= shift_q[15];
            end
            if (!lnk.chain_mode && cnt_q == dac_sli_pkg::LAST_EDGE) begin
                done_q <= ~done_q; // RULE5
            end
        end
    end

    // data out moves on the opposite edge, silent before the first capture
    always_ff @(posedge idle_clk or posedge link_rst) begin
        if (link_rst) begin
            sdo_q <= 1'b0;
        end else if (!frame_sel_n && !first) begin
            sdo_q <= out_bit_q; // RULE6 RULE11
        end
    end

    a_shift_bit: assert property (@(posedge act_clk) disable iff (frame_clr) // RULE3
        shift_en |=> shift_q[0] == $past(serial_data_in))
        else $error("serial bit not captured");
    // seen at the launching edge after the final capture; no extra capture is needed
    a_word_done: assert property (@(posedge idle_clk) disable iff (frame_clr) // RULE5
        !lnk.chain_mode && cnt_q == dac_sli_pkg::WORD_EDGES
        && $past(cnt_q) == dac_sli_pkg::LAST_EDGE |-> done_q != $past(done_q))
        else $error("word not complete on final edge");
    a_out_edge: assert property (@(posedge idle_clk) disable iff (frame_clr) // RULE6
        !first |=> sdo_q == $past(out_bit_q))
        else $error("data out not moved on opposite edge");
endmodule

// *** src/dac_serial_load_interface.sv ***
// Purpose: load interface of a 12-bit converter register, AXI4-Lite view
// Assumes: serial pins belong to the serial clock; aclk is unrelated
// Notes: clk_en freezes aclk-side state; the serial side runs on sclk
//
// Behaviour
// RULE1 - capture on falling serial edge after reset
// RULE2 - rising-edge command switches capture edge
// RULE3 - sixteen-bit shift register, one bit per edge
// RULE4 - frame select low enables clock and data
// RULE5 - stand-alone word completes on sixteenth edge
// RULE6 - data out changes on opposite edge
// RULE7 - readback command shows converter register serially
// RULE8 - top four bits command, low twelve data
// RULE9 - chained mode at reset, execute on release
// RULE10 - early release discards stand-alone word
// RULE11 - inactive edge before first capture ignored
`timescale 1ns/1ps
module dac_serial_load_interface #(
    parameter int AW = 12
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic [AW-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [AW-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire logic sclk,
    input wire logic frame_sel_n,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic [11:0] dac_code
);
    ////////////////////////////////////////////////////////////////////
    // elaboration check
    if (AW < 5 || AW > 32) begin : g_bad_aw
        $error("address width must lie in 5..32");
    end

    ////////////////////////////////////////////////////////////////////
    // declarations
    shift_link_if lnk (); // bundle to the serial side
    logic fs_s1_q; // frame select synchroniser, first stage
    logic fs_s2_q;
    logic fs_prev_q; // for release detection
    logic dn_s1_q; // stand-alone done toggle synchroniser
    logic dn_s2_q;
    logic dn_prev_q;
    logic ak_s1_q; // readback taken toggle synchroniser
    logic ak_s2_q;
    logic ak_prev_q;
    logic fs_rise; // frame released
    logic dn_evt; // stand-alone word complete
    logic ak_evt; // readback word taken
    logic exec_go; // execute the command in the shift register
    dac_sli_pkg::cmd_e cmd;
    logic [11:0] data;
    logic [11:0] dac_q; // converter register
    logic rise_q; // capture on rising edges
    logic chain_q; // chained mode
    logic rb_pend_q; // readback armed
    logic [15:0] last_q; // last executed word
    logic defaults_w; // software restores power-on modes
    // write channel
    logic awready_q;
    logic wready_q;
    logic aw_got_q;
    logic w_got_q;
    logic [AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic aw_take;
    logic w_take;
    logic wr_go;
    dac_sli_pkg::reg_e wr_sel;
    // read channel
    logic arready_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0] rresp_q;
    logic ar_take;
    dac_sli_pkg::reg_e rd_sel;
    logic [31:0] rd_mux;
    logic [31:0] status_w;

    ////////////////////////////////////////////////////////////////////
    // address decode shared by both channels
    function automatic dac_sli_pkg::reg_e reg_sel(input logic [AW-1:0] a);
        dac_sli_pkg::reg_e s;
        s = dac_sli_pkg::REG_NONE;
        if (a == AW'(dac_sli_pkg::ADDR_STATUS)) begin
            s = dac_sli_pkg::REG_STATUS;
        end else if (a == AW'(dac_sli_pkg::ADDR_WORD)) begin
            s = dac_sli_pkg::REG_WORD;
        end else if (a == AW'(dac_sli_pkg::ADDR_CTRL)) begin
            s = dac_sli_pkg::REG_CTRL;
        end
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // serial side
    serial_shifter u_shift (
        .sclk(sclk),
        .link_rst(!aresetn),
        .frame_sel_n(frame_sel_n),
        .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out),
        .lnk(lnk)
    );

    // commands change mode fields on release or after the final edge of a stand-alone word; a mid-word change would glitch the edge mux
    assign lnk.rise_mode = rise_q;
    assign lnk.chain_mode = chain_q;
    assign lnk.rb_pend = rb_pend_q;
    assign lnk.rb_word = {4'h0, dac_q};

    ////////////////////////////////////////////////////////////////////
    // synchronisers: frame pin level and the two event toggles
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fs_s1_q <= 1'b1;
            fs_s2_q <= 1'b1;
            fs_prev_q <= 1'b1;
            dn_s1_q <= 1'b0;
            dn_s2_q <= 1'b0;
            dn_prev_q <= 1'b0;
            ak_s1_q <= 1'b0;
            ak_s2_q <= 1'b0;
            ak_prev_q <= 1'b0;
        end else if (clk_en) begin
            fs_s1_q <= frame_sel_n;
            fs_s2_q <= fs_s1_q;
            fs_prev_q <= fs_s2_q;
            dn_s1_q <= lnk.done_tgl;
            dn_s2_q <= dn_s1_q;
            dn_prev_q <= dn_s2_q;
            ak_s1_q <= lnk.ack_tgl;
            ak_s2_q <= ak_s1_q;
            ak_prev_q <= ak_s2_q;
        end
    end

    assign fs_rise = fs_s2_q && !fs_prev_q;
    assign dn_evt = dn_s2_q ^ dn_prev_q;
    assign ak_evt = ak_s2_q ^ ak_prev_q;
    // shift word is stable here: serial clock is idle or word is full
    assign exec_go = clk_en && (chain_q ? fs_rise : dn_evt); // RULE5 RULE9
    assign cmd = dac_sli_pkg::cmd_e'(lnk.word[15:12]); // RULE8
    assign data = lnk.word[11:0]; // RULE8

    ////////////////////////////////////////////////////////////////////
    // converter register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dac_q <= dac_sli_pkg::DAC_RST;
        end else if (exec_go) begin
            case (cmd)
                dac_sli_pkg::CMD_LOAD: dac_q <= data; // RULE8
                dac_sli_pkg::CMD_CLEAR_ZERO: dac_q <= dac_sli_pkg::CODE_ZERO; // RULE8
                dac_sli_pkg::CMD_CLEAR_MID: dac_q <= dac_sli_pkg::CODE_MID; // RULE8
                default: dac_q <= dac_q; // no operation and reserved codes leave it alone
            endcase
        end
    end

    // operating modes; a command in the same cycle beats a restore
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rise_q <= dac_sli_pkg::RISE_RST; // RULE1
            chain_q <= dac_sli_pkg::CHAIN_RST; // RULE9
        end else if (clk_en) begin
            if (defaults_w) begin
                rise_q <= dac_sli_pkg::RISE_RST;
                chain_q <= dac_sli_pkg::CHAIN_RST;
            end
            if (exec_go && cmd == dac_sli_pkg::CMD_RISE_EDGE) begin
                rise_q <= 1'b1; // RULE2
            end
            if (exec_go && cmd == dac_sli_pkg::CMD_CHAIN_OFF) begin
                chain_q <= 1'b0; // RULE8
            end
        end
    end

    // readback arm: a new arm wins over the take of the old one
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rb_pend_q <= 1'b0;
        end else if (exec_go && cmd == dac_sli_pkg::CMD_READBACK) begin
            rb_pend_q <= 1'b1; // RULE7
        end else if (clk_en && ak_evt) begin
            rb_pend_q <= 1'b0;
        end
    end

    // last executed word for software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            last_q <= 16'h0000;
        end else if (exec_go) begin
            last_q <= lnk.word;
        end
    end

    assign dac_code = dac_q;

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data in either order
    assign aw_take = awvalid && awready_q;
    assign w_take = wvalid && wready_q;
    assign wr_go = aw_got_q && w_got_q && !bvalid_q;
    assign wr_sel = reg_sel(awaddr_q);
    assign defaults_w = wr_go && wr_sel == dac_sli_pkg::REG_CTRL
        && wstrb_q[0] && wdata_q[dac_sli_pkg::CTRL_DEFAULTS_BIT];

    // address holder
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_q <= 1'b0;
            aw_got_q <= 1'b0;
            awaddr_q <= '0;
        end else if (clk_en) begin
            if (aw_take) begin
                awaddr_q <= awaddr;
                aw_got_q <= 1'b1;
                awready_q <= 1'b0;
            end else if (wr_go) begin
                aw_got_q <= 1'b0;
            end else if (!aw_got_q && !bvalid_q) begin
                awready_q <= 1'b1;
            end
        end
    end

    // data holder
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready_q <= 1'b0;
            w_got_q <= 1'b0;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
        end else if (clk_en) begin
            if (w_take) begin
                wdata_q <= wdata;
                wstrb_q <= wstrb;
                w_got_q <= 1'b1;
                wready_q <= 1'b0;
            end else if (wr_go) begin
                w_got_q <= 1'b0;
            end else if (!w_got_q && !bvalid_q) begin
                wready_q <= 1'b1;
            end
        end
    end

    // write response; read-only registers take writes silently
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= dac_sli_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q <= (wr_sel == dac_sli_pkg::REG_NONE) ?
                    dac_sli_pkg::RESP_SLVERR : dac_sli_pkg::RESP_OKAY;
            end else if (bvalid_q && bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;

    ////////////////////////////////////////////////////////////////////
    // AXI4-Lite read
    assign ar_take = arvalid && arready_q;
    assign rd_sel = reg_sel(araddr);

    // status word and read mux
    always_comb begin
        status_w = 32'h0000_0000;
        status_w[11:0] = dac_q;
        status_w[dac_sli_pkg::STAT_RISE_BIT] = rise_q;
        status_w[dac_sli_pkg::STAT_CHAIN_BIT] = chain_q;
        status_w[dac_sli_pkg::STAT_RBPEND_BIT] = rb_pend_q;
        status_w[dac_sli_pkg::STAT_FRAME_BIT] = !fs_s2_q;
        case (rd_sel)
            dac_sli_pkg::REG_STATUS: rd_mux = status_w;
            dac_sli_pkg::REG_WORD: rd_mux = {16'h0000, last_q};
            default: rd_mux = 32'h0000_0000; // control reads as zero
        endcase
    end

    // one read at a time, answered the cycle after the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
            rresp_q <= dac_sli_pkg::RESP_OKAY;
        end else if (clk_en) begin
            if (ar_take) begin
                arready_q <= 1'b0;
                rvalid_q <= 1'b1;
                rdata_q <= rd_mux;
                rresp_q <= (rd_sel == dac_sli_pkg::REG_NONE) ?
                    dac_sli_pkg::RESP_SLVERR : dac_sli_pkg::RESP_OKAY;
            end else if (rvalid_q && rready) begin
                rvalid_q <= 1'b0;
            end else if (!rvalid_q) begin
                arready_q <= 1'b1;
            end
        end
    end

    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_power_modes: assert property ( // RULE1 RULE9
        $rose(aresetn) |-> chain_q && !rise_q)
        else $error("modes not at power-on values");
    a_rise_switch: assert property ( // RULE2
        exec_go && cmd == dac_sli_pkg::CMD_RISE_EDGE |=> rise_q)
        else $error("rising capture not selected");
    a_alone_load: assert property ( // RULE5
        clk_en && !chain_q && dn_evt && cmd == dac_sli_pkg::CMD_LOAD |=> dac_q == $past(data))
        else $error("stand-alone load not applied");
    a_chain_load: assert property ( // RULE9
        clk_en && chain_q && fs_rise && cmd == dac_sli_pkg::CMD_LOAD |=> dac_q == $past(data))
        else $error("chained load not applied on release");
    a_rb_arm: assert property ( // RULE7
        exec_go && cmd == dac_sli_pkg::CMD_READBACK |=> rb_pend_q && $stable(dac_q))
        else $error("readback not armed");
    a_clear_mid: assert property ( // RULE8
        exec_go && cmd == dac_sli_pkg::CMD_CLEAR_MID |=> dac_q == 12'h800)
        else $error("midscale clear wrong");
    a_abort_hold: assert property ( // RULE10
        clk_en && !chain_q && !dn_evt && !defaults_w |=> $stable(dac_q) && $stable(chain_q))
        else $error("discarded word changed state");
    a_chain_wait: assert property ( // RULE9
        chain_q && !fs_rise |=> $stable(dac_q))
        else $error("chained word executed before release");
endmodule

// *** bench/serial_host.sv ***
// Purpose: host serial master facing the load interface
// Assumes: link clock of 125 ns, stands still outside frames
// Notes: sclk keeps its last level between frames, so a frame can open on an inactive edge
`timescale 1ns/1ps
module serial_host (
    output logic sclk,
    output logic frame_sel_n,
    output logic serial_data_in,
    input wire logic serial_data_out
);
    localparam realtime HALF = 62.5; // half link period
    logic moved = 1'b0; // data out seen moving on a capturing edge
    ////////////////////////////////////////////////////////////////////////////////
    // idle pins at time zero
    initial begin
        sclk = 1'b0;
        frame_sel_n = 1'b1;
        serial_data_in = 1'b0;
    end
    // drop select, clock n bits msb first, collect data out; rel ends the frame
    task automatic frame(input logic [15:0] w, input int n, input logic rise, input bit rel,
        output logic [15:0] got);
        logic a;
        logic s0;
        a = ~rise; // level just before a capturing edge
        got = '0;
        frame_sel_n = 1'b0;
        serial_data_in = w[15];
        #(HALF);
        // wrong level: the opening edge is an inactive one, to be ignored
        if (sclk !== a) begin
            sclk = a;
            #(HALF);
        end
        for (int i = 0; i < n; i++) begin
            s0 = serial_data_out;
            sclk = ~a; // capturing edge
            #5;
            if (serial_data_out !== s0) begin
                moved = 1'b1;
            end
            #(HALF - 5);
            sclk = a; // launching edge, next bit goes out here
            serial_data_in = w[15 - ((i + 1) % 16)];
            #(HALF);
            got = {got[14:0], serial_data_out};
        end
        if (rel) begin
            release_frame();
        end
    endtask
    // raise select; released data line shows the inverse, not the last bit
    task automatic release_frame();
        #(HALF);
        frame_sel_n = 1'b1;
        serial_data_in = ~serial_data_in;
        #(HALF * 2);
    endtask
endmodule

// *** bench/tb_dac_serial_load_interface.sv ***
// Purpose: self-checking bench of the load interface
// Assumes: host model drives the link, bench drives AXI4-Lite
// Notes: execution latency is a few aclk, ten cycles are allowed
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin fails++; \
    $display("mismatch at %0t: got %h exp %h", $time, (g), (e)); end end
module tb_dac_serial_load_interface;
    logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic arvalid, arready, rvalid, rready, sclk, frame_sel_n, serial_data_in, serial_data_out;
    logic [11:0] awaddr, araddr, dac_code;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rsp;
    logic [15:0] got;
    int fails = 0;
    int n_checks = 0;
    // command words and the converter code each must leave behind
    logic [15:0] cw [5] = '{16'hc000, 16'h3fff, 16'hb000, 16'h1fed, 16'h0123};
    logic [11:0] ce [5] = '{12'h800, 12'h800, 12'h000, 12'hfed, 12'hfed};
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end
    dac_serial_load_interface dac_serial_load_interface_i (.aclk(aclk), .aresetn(aresetn),
        .clk_en(1'b1), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .sclk(sclk), .frame_sel_n(frame_sel_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out), .dac_code(dac_code));
    serial_host host_i (.sclk(sclk), .frame_sel_n(frame_sel_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out));
    ////////////////////////////////////////////////////////////////////////////////
    // write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= 4'hf;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rsp = bresp;
        bready <= 1'b0;
    endtask
    // read: rready held until rvalid is sampled
    task automatic axi_rd(input logic [11:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rsp = rresp;
        rready <= 1'b0;
    endtask
    // one closed frame, then the converter code it should leave
    task automatic run(input logic [15:0] w, input logic rise, input logic [11:0] e);
        host_i.frame(w, 16, rise, 1'b1, got);
        repeat (10) @(posedge aclk);
        `CHK(dac_code, e)
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog: the whole sequence needs well under 100 us
    initial begin
        #300000;
        fails++;
        test_done();
    end
    initial begin
        aresetn = 1'b0;
        awaddr = '0;
        awvalid = 1'b0;
        wdata = '0;
        wstrb = '0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = '0;
        arvalid = 1'b0;
        rready = 1'b0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (6) @(posedge aclk);
        axi_rd(dac_sli_pkg::ADDR_STATUS);
        `CHK(rd[dac_sli_pkg::STAT_RISE_BIT], 1'b0)
        `CHK(rd[dac_sli_pkg::STAT_CHAIN_BIT], 1'b1)
        axi_rd(12'h00c);
        `CHK(rsp, dac_sli_pkg::RESP_SLVERR)
        // chained: nothing happens until select rises; frame opens on an inactive edge
        host_i.frame(16'h1abc, 16, 1'b0, 1'b0, got);
        repeat (10) @(posedge aclk);
        `CHK(dac_code, 12'h000)
        host_i.release_frame();
        repeat (10) @(posedge aclk);
        `CHK(dac_code, 12'habc)
        run(16'h2000, 1'b0, 12'habc);
        host_i.frame(16'h0000, 16, 1'b0, 1'b1, got);
        `CHK(got, 16'h0abc)
        for (int i = 0; i < 5; i++) run(cw[i], 1'b0, ce[i]);
        host_i.frame(16'h9000, 16, 1'b0, 1'b1, got);
        `CHK(got, 16'h0123)
        axi_rd(dac_sli_pkg::ADDR_STATUS);
        `CHK(rd[dac_sli_pkg::STAT_CHAIN_BIT], 1'b0)
        // stand-alone: word acts on the 16th edge, select still low
        host_i.frame(16'h1321, 16, 1'b0, 1'b0, got);
        repeat (10) @(posedge aclk);
        `CHK(dac_code, 12'h321)
        host_i.release_frame();
        host_i.frame(16'h1456, 12, 1'b0, 1'b1, got);
        repeat (10) @(posedge aclk);
        `CHK(dac_code, 12'h321)
        run(16'h1777, 1'b0, 12'h777);
        run(16'ha000, 1'b0, 12'h777);
        run(16'h1aaa, 1'b1, 12'haaa);
        `CHK(host_i.moved, 1'b0)
        axi_wr(dac_sli_pkg::ADDR_CTRL, 32'h0000_0001);
        `CHK(rsp, dac_sli_pkg::RESP_OKAY)
        axi_rd(dac_sli_pkg::ADDR_STATUS);
        `CHK(rd[17:16], 2'h2)
        run(16'h1bbb, 1'b0, 12'hbbb);
        test_done();
    end
endmodule
